// file: core/cbd_pkg.sv
/*
 * Shared constants and types for the card bridge configuration bank:
 * register indices, field positions, reset values, timer lengths and
 * the interrupt signalling mode carrier.
 * Assumes an AXI4-Lite host bus with 32-bit data, one register per word.
 */
package cbd_pkg;
   localparam int ADDR_W = 12;
   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_ID = 8'h00;
   localparam logic [7:0] IDX_DEV_CTL = 8'h92;
   localparam logic [7:0] IDX_DIAG = 8'h93;
   localparam logic [7:0] IDX_IRQ_STS = 8'hB0;
   localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
   localparam logic [7:0] IDX_STATE = 8'hB2;
   // Reset values
   localparam logic [7:0] DEV_CTL_RST = 8'h66;
   localparam logic [7:0] DIAG_RST = 8'h21;
   localparam logic [2:0] IRQ_MASK_RST = 3'h0;
   // Writable and readable bits
   localparam logic [7:0] DEV_CTL_WR_MASK = 8'hEF;
   localparam logic [7:0] DIAG_RD_MASK = 8'hBF;
   // Device control fields
   localparam int DC_PWR_HOLD = 7;
   localparam int DC_LV_FORCE = 6;
   localparam int DC_LEGACY_DIAG = 5;
   localparam int DC_MODE_LO = 1;
   // Diagnostic fields
   localparam int DG_ID_MASK = 7;
   localparam int DG_CSC_ROUTE = 5;
   localparam int DG_DLY_DIS = 4;
   localparam int DG_LAT_EXT = 3;
   localparam int DG_CB_DISC = 2;
   localparam int DG_HOST_DISC = 1;
   localparam int DG_ASYNC = 0;
   // Interrupt status bits; sides of the discard timers share the low two
   localparam int IRQ_HOST_EXP = 0;
   localparam int IRQ_CB_EXP = 1;
   localparam int IRQ_CSC = 2;
   localparam int IRQ_N = 3;
   localparam int SIDE_HOST = 0;
   localparam int SIDE_CB = 1;
   // Timing counts in clocks
   localparam int LAT_SHORT = 16;
   localparam int LAT_LONG = 64;
   localparam int DISC_SHORT_LOG2 = 10;
   localparam int DISC_LONG_LOG2 = 15;
   localparam int DISC_SHORT = 2 ** DISC_SHORT_LOG2;
   localparam int DISC_LONG = 2 ** DISC_LONG_LOG2;
   localparam int DISC_CNT_W = 16;
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] ALL_ONES = 32'hFFFF_FFFF;

   typedef enum logic [1:0] {
      MODE_PAR_PCI = 2'b00,
      MODE_PAR_BOTH = 2'b01,
      MODE_SER_LEGACY = 2'b10,
      MODE_SER_BOTH = 2'b11
   } cbd_irq_mode_t;

   typedef struct packed {
      logic par_pci;
      logic par_legacy;
      logic ser_legacy;
      logic ser_pci;
   } cbd_irq_sig_t;
endpackage

// file: core/cbd_diag_regs.sv
/*
 * Card bridge device control and diagnostic register bank with its
 * AXI4-Lite slave, retry latency counter, two discard timers, socket
 * power hold, status-change routing and an event interrupt.
 * Assumes one clock, synchronous active-high reset, and request inputs
 * from logic on the same clock, except the status-change pin.
 */
`timescale 1ns/1ps

// Summary of operation
// - Power hold set ignores socket power-off requests while in D3.
// - Low-voltage force bit reports socket 3-V capable when 1; resets to 1.
// - Mode field picks parallel or serialized legacy and PCI interrupts; resets 11.
// - Device control bit 4 is read-only and always reads 0.
// - Device control bit 5 is a writable diagnostic bit resetting to 1.
// - Identifier mask set makes vendor and device identifier reads all ones.
// - Diagnostic bit 6 is reserved and always reads 0.
// - Routing bit chooses legacy 803 bit 4 or 805 bits 7-4 zero.
// - Diagnostic bit 4 disables delayed transactions for host accesses.
// - Diagnostic bit 3 stretches retry latency threshold from 16 to 64.
// - Card-side discard timer lasts 2^10 clocks if selected, else 2^15.
// - Host-side discard timer lasts 2^10 clocks if selected, else 2^15.
// - Async enable passes status-change interrupts unclocked; else synchronised.
// - Retry expiry flags set when a retried master fails to return in time.
module cbd_diag_regs #(
   parameter int DISC_SHORT_CLK = cbd_pkg::DISC_SHORT,
   parameter int DISC_LONG_CLK = cbd_pkg::DISC_LONG,
   parameter logic [15:0] VENDOR_ID = 16'h5A5A,
   parameter logic [15:0] DEVICE_ID = 16'hA5A5
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [cbd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [cbd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_state_d3,
   input wire logic socket_power_on_req,
   input wire logic socket_power_off_req,
   output logic socket_power_on,
   output logic low_voltage_capable,
   output logic legacy_io_diag_bit,
   output cbd_pkg::cbd_irq_sig_t irq_signalling,
   input wire logic legacy_csc_pci_enable,
   input wire logic [3:0] legacy_csc_irq_select,
   input wire logic card_status_change_pin,
   output logic csc_pci_irq,
   output logic csc_legacy_irq,
   output logic delayed_txn_disable,
   input wire logic target_waiting,
   output logic retry_now,
   input wire logic [1:0] txn_retried,
   input wire logic [1:0] master_returned,
   output logic [1:0] txn_discard,
   output logic irq
);
   typedef struct packed {
      logic [7:0] dev_ctl;
      logic [7:0] diag;
      logic [cbd_pkg::IRQ_N-1:0] irq_sts;
      logic [cbd_pkg::IRQ_N-1:0] irq_mask;
      logic aw_have;
      logic [cbd_pkg::ADDR_W-1:0] aw_addr;
      logic w_have;
      logic [7:0] w_data;
      logic w_lane0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sock_pwr;
      logic [6:0] lat_cnt;
      logic retry_now;
      logic [1:0][cbd_pkg::DISC_CNT_W-1:0] disc_cnt;
      logic [1:0] disc_busy;
      logic [1:0] discard;
      logic csc_s1;
      logic csc_s2;
      logic csc_s3;
   } cbd_state_t;

   cbd_state_t st_reg;
   cbd_state_t st_next;

   function automatic logic [cbd_pkg::ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = cbd_pkg::ADDR_W'({idx, 2'b00});
   endfunction

   function automatic logic hits(input logic [cbd_pkg::ADDR_W-1:0] a,
                                 input logic [7:0] idx);
      hits = ({a[cbd_pkg::ADDR_W-1:2], 2'b00} == byte_addr(idx));
   endfunction

   // Unmapped words answer with an error and have no side effect
   function automatic logic mapped(input logic [cbd_pkg::ADDR_W-1:0] a);
      mapped = hits(a, cbd_pkg::IDX_ID) || hits(a, cbd_pkg::IDX_DEV_CTL) ||
               hits(a, cbd_pkg::IDX_DIAG) || hits(a, cbd_pkg::IDX_IRQ_STS) ||
               hits(a, cbd_pkg::IDX_IRQ_MASK) || hits(a, cbd_pkg::IDX_STATE);
   endfunction

   logic [7:0] diag_view;
   logic csc_route_pci;
   logic csc_level;
   logic [cbd_pkg::IRQ_N-1:0] irq_set;
   logic [cbd_pkg::IRQ_N-1:0] irq_clr;
   logic do_write;
   logic [6:0] lat_limit;
   logic [1:0][cbd_pkg::DISC_CNT_W-1:0] disc_last;
   cbd_pkg::cbd_irq_mode_t mode;

   // Diagnostic bit 6 is stored as written but hidden on reads
   assign diag_view = st_reg.diag & cbd_pkg::DIAG_RD_MASK;
   assign mode = cbd_pkg::cbd_irq_mode_t'(st_reg.dev_ctl[cbd_pkg::DC_MODE_LO +: 2]);

   // Route status-change interrupts to PCI or to the legacy IRQ
   always_comb begin
      if (st_reg.diag[cbd_pkg::DG_CSC_ROUTE]) begin
         csc_route_pci = (legacy_csc_irq_select == 4'h0);
      end else begin
         csc_route_pci = legacy_csc_pci_enable;
      end
   end

   // Unclocked path is a deliberate pass-through of the card pin
   // Users of the async path must tolerate glitches and metastable levels on it
   assign csc_level = st_reg.diag[cbd_pkg::DG_ASYNC] ? card_status_change_pin
                                                     : st_reg.csc_s2;
   assign csc_pci_irq = csc_level & csc_route_pci;
   assign csc_legacy_irq = csc_level & ~csc_route_pci;

   // Mode decode onto the four signalling enables
   // Serial modes only flag the enables; the serializer itself lives outside
   always_comb begin
      irq_signalling = '0;
      unique case (mode)
         cbd_pkg::MODE_PAR_PCI: begin
            irq_signalling.par_pci = 1'b1;
         end
         cbd_pkg::MODE_PAR_BOTH: begin
            irq_signalling.par_pci = 1'b1;
            irq_signalling.par_legacy = 1'b1;
         end
         cbd_pkg::MODE_SER_LEGACY: begin
            irq_signalling.par_pci = 1'b1;
            irq_signalling.ser_legacy = 1'b1;
         end
         cbd_pkg::MODE_SER_BOTH: begin
            irq_signalling.ser_legacy = 1'b1;
            irq_signalling.ser_pci = 1'b1;
         end
      endcase
   end

   assign lat_limit = st_reg.diag[cbd_pkg::DG_LAT_EXT] ? 7'(cbd_pkg::LAT_LONG - 1)
                                                       : 7'(cbd_pkg::LAT_SHORT - 1);
   assign disc_last[cbd_pkg::SIDE_HOST] = st_reg.diag[cbd_pkg::DG_HOST_DISC]
      ? cbd_pkg::DISC_CNT_W'(DISC_SHORT_CLK - 1)
      : cbd_pkg::DISC_CNT_W'(DISC_LONG_CLK - 1);
   assign disc_last[cbd_pkg::SIDE_CB] = st_reg.diag[cbd_pkg::DG_CB_DISC]
      ? cbd_pkg::DISC_CNT_W'(DISC_SHORT_CLK - 1)
      : cbd_pkg::DISC_CNT_W'(DISC_LONG_CLK - 1);

   // A write commits only with both halves held and no answer pending,
   // so a slow bready stalls the next write instead of losing its answer
   assign do_write = st_reg.aw_have && st_reg.w_have && !st_reg.bvalid;

   always_comb begin
      st_next = st_reg;
      irq_set = '0;
      irq_clr = '0;
      st_next.retry_now = 1'b0;
      st_next.discard = 2'b00;

      // Synchroniser and edge detect for the status-change pin
      st_next.csc_s1 = card_status_change_pin;
      st_next.csc_s2 = st_reg.csc_s1;
      st_next.csc_s3 = st_reg.csc_s2;
      irq_set[cbd_pkg::IRQ_CSC] = st_reg.csc_s2 & ~st_reg.csc_s3;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_next.w_have = 1'b1;
         st_next.w_data = s_axi_wdata[7:0];
         st_next.w_lane0 = s_axi_wstrb[0];
      end
      if (do_write) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = mapped(st_reg.aw_addr) ? cbd_pkg::RESP_OKAY
                                                : cbd_pkg::RESP_SLVERR;
         if (st_reg.w_lane0) begin
            if (hits(st_reg.aw_addr, cbd_pkg::IDX_DEV_CTL)) begin
               // Test bits 0 and 3 are stored as written; bit 4 never changes
               st_next.dev_ctl = st_reg.w_data & cbd_pkg::DEV_CTL_WR_MASK;
            end
            if (hits(st_reg.aw_addr, cbd_pkg::IDX_DIAG)) begin
               st_next.diag = st_reg.w_data;
            end
            if (hits(st_reg.aw_addr, cbd_pkg::IDX_IRQ_STS)) begin
               irq_clr = st_reg.w_data[cbd_pkg::IRQ_N-1:0];
            end
            if (hits(st_reg.aw_addr, cbd_pkg::IDX_IRQ_MASK)) begin
               st_next.irq_mask = st_reg.w_data[cbd_pkg::IRQ_N-1:0];
            end
         end
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // Read channel: answer one cycle after the address is taken
      // Data is captured at acceptance, so a later write cannot alter a pending answer
      if (s_axi_arvalid && s_axi_arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = mapped(s_axi_araddr) ? cbd_pkg::RESP_OKAY
                                              : cbd_pkg::RESP_SLVERR;
         st_next.rdata = '0;
         if (hits(s_axi_araddr, cbd_pkg::IDX_ID)) begin
            st_next.rdata = st_reg.diag[cbd_pkg::DG_ID_MASK] ? cbd_pkg::ALL_ONES
                                                             : {DEVICE_ID, VENDOR_ID};
         end
         if (hits(s_axi_araddr, cbd_pkg::IDX_DEV_CTL)) begin
            st_next.rdata = {24'h00_0000, st_reg.dev_ctl};
         end
         if (hits(s_axi_araddr, cbd_pkg::IDX_DIAG)) begin
            st_next.rdata = {24'h00_0000, diag_view};
         end
         if (hits(s_axi_araddr, cbd_pkg::IDX_IRQ_STS)) begin
            st_next.rdata = {29'h0000_0000, st_reg.irq_sts};
         end
         if (hits(s_axi_araddr, cbd_pkg::IDX_IRQ_MASK)) begin
            st_next.rdata = {29'h0000_0000, st_reg.irq_mask};
         end
         if (hits(s_axi_araddr, cbd_pkg::IDX_STATE)) begin
            st_next.rdata = {27'h000_0000, st_reg.csc_s2, st_reg.disc_busy,
                             st_reg.sock_pwr, power_state_d3};
         end
      end else if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // Socket power; an on request wins over an off request
      // Outside D3 the hold bit has no effect, so normal power management still works
      if (socket_power_on_req) begin
         st_next.sock_pwr = 1'b1;
      end else if (socket_power_off_req &&
                   !(st_reg.dev_ctl[cbd_pkg::DC_PWR_HOLD] && power_state_d3)) begin
         st_next.sock_pwr = 1'b0;
      end

      // Retry latency: a target waiting this long gets a retry
      // Dropping target_waiting restarts the count, so a retry needs an unbroken wait
      if (!target_waiting) begin
         st_next.lat_cnt = '0;
      end else if (st_reg.lat_cnt >= lat_limit) begin
         st_next.lat_cnt = '0;
         st_next.retry_now = 1'b1;
      end else begin
         st_next.lat_cnt = st_reg.lat_cnt + 7'd1;
      end

      // Discard timers, one per side
      // A returning master cancels the timer even in the cycle it would expire
      for (int s = 0; s < 2; s++) begin
         if (master_returned[s]) begin
            st_next.disc_busy[s] = 1'b0;
            st_next.disc_cnt[s] = '0;
         end else if (txn_retried[s] && !st_reg.disc_busy[s]) begin
            st_next.disc_busy[s] = 1'b1;
            st_next.disc_cnt[s] = '0;
         end else if (st_reg.disc_busy[s]) begin
            if (st_reg.disc_cnt[s] >= disc_last[s]) begin
               st_next.disc_busy[s] = 1'b0;
               st_next.disc_cnt[s] = '0;
               st_next.discard[s] = 1'b1;
               irq_set[s] = 1'b1;
            end else begin
               st_next.disc_cnt[s] = st_reg.disc_cnt[s] + cbd_pkg::DISC_CNT_W'(1);
            end
         end
      end

      // Sticky flags: a new event wins over a write-one clear
      st_next.irq_sts = (st_reg.irq_sts & ~irq_clr) | irq_set;
   end

   // Synchronous reset; every field not named below starts at zero
   always_ff @(posedge clk) begin
      if (srst) begin
         st_reg <= '0;
         st_reg.dev_ctl <= cbd_pkg::DEV_CTL_RST;
         st_reg.diag <= cbd_pkg::DIAG_RST;
         st_reg.irq_mask <= cbd_pkg::IRQ_MASK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Readies drop while a half is held or an answer waits: one transfer at a time
   assign s_axi_awready = !st_reg.aw_have && !st_reg.bvalid;
   assign s_axi_wready = !st_reg.w_have && !st_reg.bvalid;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;

   assign socket_power_on = st_reg.sock_pwr;
   assign low_voltage_capable = st_reg.dev_ctl[cbd_pkg::DC_LV_FORCE];
   assign legacy_io_diag_bit = st_reg.dev_ctl[cbd_pkg::DC_LEGACY_DIAG];
   assign delayed_txn_disable = st_reg.diag[cbd_pkg::DG_DLY_DIS];
   assign retry_now = st_reg.retry_now;
   assign txn_discard = st_reg.discard;
   // Level interrupt: stays high until software clears the status or the mask
   assign irq = |(st_reg.irq_sts & st_reg.irq_mask);
endmodule

// file: sim/cbd_diag_regs_asserts.sv
/* Port assertions for cbd_diag_regs: bus answers, read fields, pulses.
   Assumes the single clock and synchronous active-high reset of the bank. */
`timescale 1ns/1ps
module cbd_diag_regs_asserts #(
   parameter int DISC_SHORT_CLK = 8,
   parameter int DISC_LONG_CLK = 32,
   parameter logic [15:0] VENDOR_ID = 16'h0F0F,
   parameter logic [15:0] DEVICE_ID = 16'hF0F0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [cbd_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire cbd_pkg::cbd_irq_sig_t irq_signalling,
   input wire logic socket_power_on,
   input wire logic socket_power_off_req,
   input wire logic low_voltage_capable,
   input wire logic legacy_io_diag_bit,
   input wire logic delayed_txn_disable,
   input wire logic csc_pci_irq,
   input wire logic csc_legacy_irq,
   input wire logic target_waiting,
   input wire logic retry_now
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_rd_lat;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_dc_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h248 |=> s_axi_rdata[4] == 1'b0
         && s_axi_rdata[6] == $past(low_voltage_capable)
         && s_axi_rdata[5] == $past(legacy_io_diag_bit);
   endproperty
   a_dc_read: assert property (p_dc_read) else $error("control read wrong");
   property p_dg_read;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h24C |=> s_axi_rdata[6] == 1'b0
         && s_axi_rdata[4] == $past(delayed_txn_disable);
   endproperty
   a_dg_read: assert property (p_dg_read) else $error("diagnostic read wrong");
   property p_id;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h000
         |=> s_axi_rdata == cbd_pkg::ALL_ONES || s_axi_rdata == {DEVICE_ID, VENDOR_ID};
   endproperty
   a_id: assert property (p_id) else $error("identifier read wrong");
   property p_unmapped;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h250
         |=> s_axi_rresp == cbd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read accepted");
   property p_mode;
      irq_signalling inside {4'h8, 4'hC, 4'hA, 4'h3};
   endproperty
   a_mode: assert property (p_mode) else $error("illegal signalling mode");
   property p_csc_excl;
      !(csc_pci_irq && csc_legacy_irq);
   endproperty
   a_csc_excl: assert property (p_csc_excl) else $error("status change on both routes");
   property p_retry_gap;
      retry_now |=> !retry_now [*8];
   endproperty
   a_retry_gap: assert property (p_retry_gap) else $error("retry pulses too close");
   property p_retry_cause;
      retry_now |-> $past(target_waiting);
   endproperty
   a_retry_cause: assert property (p_retry_cause) else $error("retry without waiter");
   property p_pwr_off;
      $fell(socket_power_on) |-> $past(socket_power_off_req) || $past(srst);
   endproperty
   a_pwr_off: assert property (p_pwr_off) else $error("power removed unasked");
endmodule

bind cbd_diag_regs cbd_diag_regs_asserts #(.DISC_SHORT_CLK(DISC_SHORT_CLK),
   .DISC_LONG_CLK(DISC_LONG_CLK), .VENDOR_ID(VENDOR_ID), .DEVICE_ID(DEVICE_ID)) i_chk (
   .clk, .srst, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
   .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .irq_signalling,
   .socket_power_on, .socket_power_off_req, .low_voltage_capable, .legacy_io_diag_bit,
   .delayed_txn_disable, .csc_pci_irq, .csc_legacy_irq, .target_waiting, .retry_now);

// file: sim/cbd_diag_regs_tb.sv
/* Self-checking bench for cbd_diag_regs over AXI4-Lite and side ports.
   Assumes discard timers shortened to 8 and 32 clocks. */
`timescale 1ns/1ps
module cbd_diag_regs_tb;
   localparam int NS = 8;
   localparam int NL = 32;
   // Arbitrary identifier values
   localparam logic [15:0] VID = 16'h0F0F;
   localparam logic [15:0] DID = 16'hF0F0;
   localparam logic [11:0] A_DC = 12'h248;
   localparam logic [11:0] A_DG = 12'h24C;
   localparam logic [11:0] A_ST = 12'h2C0;
   localparam logic [11:0] A_MK = 12'h2C4;
   localparam logic [3:0] MODE_EXP [4] = '{4'h8, 4'hC, 4'hA, 4'h3};
   logic clk = 0, srst = 1, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, power_state_d3 = 0, socket_power_on_req = 0;
   logic socket_power_off_req = 0, legacy_csc_pci_enable = 0, card_status_change_pin = 0;
   logic target_waiting = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0;
   logic [3:0] s_axi_wstrb = '0, legacy_csc_irq_select = '0;
   logic [1:0] txn_retried = '0, master_returned = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic socket_power_on, low_voltage_capable, legacy_io_diag_bit, csc_pci_irq, csc_legacy_irq;
   logic delayed_txn_disable, retry_now;
   logic [1:0] s_axi_bresp, s_axi_rresp, txn_discard, rr;
   logic [31:0] s_axi_rdata, rv;
   cbd_pkg::cbd_irq_sig_t irq_signalling;
   int failures = 0, checks_done = 0, cycles = 0;
   always #2.5 clk = ~clk;
   cbd_diag_regs #(.DISC_SHORT_CLK(NS), .DISC_LONG_CLK(NL), .VENDOR_ID(VID), .DEVICE_ID(DID))
   i_dut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
      .power_state_d3, .socket_power_on_req, .socket_power_off_req, .socket_power_on,
      .low_voltage_capable, .legacy_io_diag_bit, .irq_signalling, .legacy_csc_pci_enable,
      .legacy_csc_irq_select, .card_status_change_pin, .csc_pci_irq, .csc_legacy_irq,
      .delayed_txn_disable, .target_waiting, .retry_now, .txn_retried, .master_returned,
      .txn_discard, .irq);
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            chk("bresp", er, s_axi_bresp);
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            rv = s_axi_rdata;
            rr = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
      chk(n, e, rv);
   endtask
   task automatic t_regs;
      chk("lv", 1, low_voltage_capable);
      chk("diagbit", 1, legacy_io_diag_bit);
      chk("mode", 4'h3, irq_signalling);
      rd("dc", A_DC, 8'h66);
      rd("dg", A_DG, 8'h21);
      rd("mask", A_MK, 8'h00);
      wr(A_DC, 8'hF6);
      rd("dc", A_DC, 8'hE6);
      for (int m = 0; m < 4; m++) begin
         wr(A_DC, 8'(m << 1));
         chk("mode", MODE_EXP[m], irq_signalling);
      end
      chk("lv", 0, low_voltage_capable);
      chk("diagbit", 0, legacy_io_diag_bit);
      wr(A_DG, 8'hFF);
      rd("dg", A_DG, 8'hBF);
      chk("dly", 1, delayed_txn_disable);
      rd("id", 12'h000, 32'hFFFF_FFFF);
      wr(A_DG, 8'h21);
      chk("dly", 0, delayed_txn_disable);
      rd("id", 12'h000, {DID, VID});
      wr(12'h250, 8'h55, cbd_pkg::RESP_SLVERR);
      rd("unmapped", 12'h250, 32'h0000_0000);
      chk("rresp", cbd_pkg::RESP_SLVERR, rr);
      $display("test registers done");
   endtask
   task automatic pwr(input logic on, input logic [7:0] dc, input logic d3, input logic e);
      wr(A_DC, dc);
      @(posedge clk);
      power_state_d3 <= d3;
      socket_power_on_req <= on;
      socket_power_off_req <= !on;
      @(posedge clk);
      socket_power_on_req <= 1'b0;
      socket_power_off_req <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("power", e, socket_power_on);
   endtask
   task automatic t_power;
      pwr(1, 8'hE6, 1, 1);
      pwr(0, 8'hE6, 1, 1);
      pwr(0, 8'hE6, 0, 0);
      pwr(1, 8'h66, 1, 1);
      rd("state", 12'h2C8, 8'h03);
      pwr(0, 8'h66, 1, 0);
      @(posedge clk) power_state_d3 <= 1'b0;
      $display("test power done");
   endtask
   task automatic gap(input logic [7:0] dg, input int e);
      int n;
      wr(A_DG, dg);
      target_waiting <= 1'b1;
      do @(posedge clk); while (retry_now !== 1'b1);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (retry_now !== 1'b1);
      chk("retry gap", e, n);
      target_waiting <= 1'b0;
   endtask
   task automatic disc(input int s, input int e, input logic ret);
      int n;
      @(posedge clk) txn_retried[s] <= 1'b1;
      @(posedge clk) txn_retried[s] <= 1'b0;
      master_returned[s] <= ret;
      @(posedge clk) master_returned[s] <= 1'b0;
      n = 1;
      while (txn_discard[s] !== 1'b1 && n < NL + 8) begin
         @(posedge clk);
         n++;
      end
      chk("discard at", e, n);
   endtask
   task automatic t_timers;
      gap(8'h21, 16);
      gap(8'h29, 64);
      wr(A_DG, 8'h23);
      disc(0, NS + 1, 0);
      disc(1, NL + 1, 0);
      chk("irq masked", 0, irq);
      wr(A_MK, 8'h07);
      chk("irq", 1, irq);
      rd("status", A_ST, 8'h03);
      wr(A_ST, 8'h03);
      chk("irq", 0, irq);
      wr(A_DG, 8'h25);
      disc(0, NL + 1, 0);
      disc(1, NS + 1, 0);
      wr(A_ST, 8'h03);
      disc(0, NL + 8, 1);
      rd("status", A_ST, 8'h00);
      $display("test timers done");
   endtask
   task automatic t_csc;
      wr(A_DG, 8'h21);
      card_status_change_pin <= 1'b1;
      #1 chk("pci", 1, csc_pci_irq);
      @(posedge clk) legacy_csc_irq_select <= 4'h3;
      #1 chk("legacy", 1, csc_legacy_irq);
      @(posedge clk) card_status_change_pin <= 1'b0;
      legacy_csc_irq_select <= 4'h0;
      wr(A_DG, 8'h00);
      wr(A_ST, 8'h04);
      legacy_csc_pci_enable <= 1'b1;
      @(posedge clk) card_status_change_pin <= 1'b1;
      #1 chk("pci sync", 0, csc_pci_irq);
      @(posedge clk);
      #1 chk("pci sync", 0, csc_pci_irq);
      @(posedge clk);
      #1 chk("pci", 1, csc_pci_irq);
      @(posedge clk) legacy_csc_pci_enable <= 1'b0;
      #1 chk("legacy", 1, csc_legacy_irq);
      @(posedge clk) card_status_change_pin <= 1'b0;
      rd("status", A_ST, 8'h04);
      chk("irq csc", 1, irq);
      wr(A_ST, 8'h04);
      chk("irq csc", 0, irq);
      $display("test status change done");
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         stop_test;
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      srst <= 1'b0;
      t_regs;
      t_power;
      t_timers;
      t_csc;
      stop_test;
   end
endmodule
